// ===== smfdc_host.sv
// Purpose: Behavioural bus host driving the two-wire link
// Assumes: Pull-up on the data line; clock stands high between frames
// Notes:   Timing is off the system clock grid on purpose
`timescale 1ns/1ps
module smfdc_host #(
   parameter int Q = 203,
   parameter int H = 407
) (
   output logic      scl_clk,
   output logic      sda_low,
   input  wire logic sda_level
);
   initial begin
      scl_clk = 1'b1;
      sda_low = 1'b0;
   end

   task automatic bit_out(input logic b);
      sda_low = ~b;
      #Q scl_clk = 1'b1;
      #H scl_clk = 1'b0;
      #Q;
   endtask : bit_out

   task automatic bit_in(output logic b);
      sda_low = 1'b0;
      #Q scl_clk = 1'b1;
      #(H / 2) b = sda_level;
      #(H - H / 2) scl_clk = 1'b0;
      #Q;
   endtask : bit_in

   task automatic start();
      sda_low = 1'b1;
      #H scl_clk = 1'b0;
      #Q;
   endtask : start

   task automatic stop();
      sda_low = 1'b1;
      #Q scl_clk = 1'b1;
      #Q sda_low = 1'b0;
      #H;
   endtask : stop

   // Sends the top n bits, MSB first; acknowledge only for a whole byte
   task automatic send(input logic [7:0] d, input int n, output logic ack);
      logic b;
      b = 1'b1;
      for (int i = 7; i > 7 - n; i--) bit_out(d[i]);
      if (n == 8) bit_in(b);
      ack = ~b;
   endtask : send

   task automatic write_cmd(input logic [6:0] a, input logic [7:0] cmd, input int n,
                            output logic [1:0] acks);
      start();
      send({a, 1'b0}, 8, acks[1]);
      acks[0] = 1'b0;
      if (acks[1]) send(cmd, n, acks[0]);
      stop();
   endtask : write_cmd

   // Acks extra bytes to get fresh status, then nacks the last one
   task automatic read_stat(input logic [6:0] a, input int extra, output logic [7:0] d,
                            output logic ack);
      start();
      send({a, 1'b1}, 8, ack);
      d = 8'h00;
      if (ack) begin
         for (int n = extra; n >= 0; n--) begin
            for (int i = 7; i >= 0; i--) bit_in(d[i]);
            bit_out(n == 0);
         end
      end
      stop();
   endtask : read_stat
endmodule : smfdc_host

// ===== smfdc_link_capture.sv
// Purpose: Samples the data line on each rising bus clock edge
// Assumes: Bus clock may stand still between frames
// Notes:   Toggle marks each new bit for the system clock side
`timescale 1ns/1ps
module smfdc_link_capture (
   input  wire logic scl_clk,
   input  wire logic rst,
   input  wire logic sda_level,
   output logic      bit_value,
   output logic      bit_toggle
);

   typedef struct packed {
      logic value;
      logic toggle;
   } smfdc_link_st_t;

   smfdc_link_st_t q;
   smfdc_link_st_t d;

   always_comb begin
      d.value  = sda_level;
      d.toggle = ~q.toggle;
   end

   // Reset does not wait for a bus clock that may never come
   always_ff @(posedge scl_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign bit_value  = q.value;
   assign bit_toggle = q.toggle;

endmodule : smfdc_link_capture

// ===== smfdc_pkg.sv
// Purpose: Shared constants and types of the fan supply DAC control slave
// Assumes: System clock of 125 MHz
// Notes:   Slave address is fixed; all counts derive from named times
package smfdc_pkg;

   // Clock and timing
   localparam int unsigned SYS_CLK_HZ    = 125_000_000;
   localparam int unsigned BOOST_TIME_MS = 250;
   localparam int unsigned BOOST_CYCLES  = BOOST_TIME_MS * (SYS_CLK_HZ / 1000);

   // Addressing
   localparam logic [6:0]  SLAVE_ADDR    = 7'h74;
   localparam logic        DIR_READ      = 1'b1;

   // Command byte layout
   localparam int unsigned CODE_W        = 6;
   localparam int unsigned CMD_CODE_LSB  = 0;
   localparam int unsigned CMD_BOOST_BIT = 6;

   // Status byte layout
   localparam int unsigned STAT_OC_BIT   = 7;
   localparam int unsigned STAT_OT_BIT   = 6;
   localparam logic [7:0]  STAT_ZERO     = 8'h00;

   // Output codes, reset value and last bit index
   localparam logic [5:0]  CODE_RST      = 6'h00;
   localparam logic [5:0]  CODE_FULL     = 6'h3f;
   localparam logic [2:0]  BIT_LAST      = 3'h7;

   // Synchroniser lanes
   localparam int unsigned SYNC_W        = 6;
   localparam int unsigned SY_SCL        = 0;
   localparam int unsigned SY_SDA        = 1;
   localparam int unsigned SY_OC         = 2;
   localparam int unsigned SY_OT         = 3;
   localparam int unsigned SY_UNDERVOLTAGE_LOCKOUT       = 4;
   localparam int unsigned SY_TGL        = 5;
   localparam logic [5:0]  SYNC_RST      = 6'h03;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_CMD,
      ST_CMD_ACK,
      ST_TX,
      ST_TX_ACK,
      ST_RELOAD
   } smfdc_state_t;

endpackage : smfdc_pkg

// ===== smfdc_props.sv
// Purpose: Concurrent checks on the fan supply DAC control slave ports
// Assumes: All checks run on sys_clk; bus pins are sampled as levels
// Notes:   Bound to smfdc_top below the module
`timescale 1ns/1ps
module smfdc_props #(
   parameter int unsigned BOOST_CYCLES = smfdc_pkg::BOOST_CYCLES
) (
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       scl_clk,
   input wire logic       sda_level,
   input wire logic       sda_drive,
   input wire logic       sda_drive_en,
   input wire logic       current_limit,
   input wire logic       thermal_shutdown,
   input wire logic       undervoltage_lockout,
   input wire logic [5:0] regulator_output,
   input wire logic       boost_active,
   input wire logic       pass_enable,
   input wire logic       overcurrent_flag,
   input wire logic       overtemp_flag,
   input wire logic       link_busy
);
   int unsigned boost_cnt_q;
   int unsigned boost_cnt_d;

   always_comb begin
      boost_cnt_d = boost_active ? boost_cnt_q + 1 : 0;
   end

   always_ff @(posedge sys_clk) begin
      boost_cnt_q <= rst ? 0 : boost_cnt_d;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence ot_rise;
      $rose(thermal_shutdown);
   endsequence
   sequence ot_seen;
      ##[1:5] (overtemp_flag && !pass_enable);
   endsequence

   chk_drive_low: assert property (sda_drive_en |-> !sda_drive)
      else $error("data line driven high");
   chk_ack_edge: assert property ($changed(sda_drive_en)
      |-> !scl_clk && !$past(scl_clk, 2))
      else $error("data line changed while bus clock high");
   chk_ack_busy: assert property (sda_drive_en |-> link_busy)
      else $error("data line pulled while slave idle");
   chk_boost_full: assert property (boost_active && $past(boost_active)
      |-> regulator_output == 6'h3f)
      else $error("boost not at full scale");
   chk_boost_len: assert property ($fell(boost_active) && !undervoltage_lockout
      |-> boost_cnt_q + 1 >= BOOST_CYCLES && boost_cnt_q <= BOOST_CYCLES + 1)
      else $error("boost length wrong");
   chk_oc_live: assert property ($rose(current_limit) |-> ##[1:4] overcurrent_flag)
      else $error("overcurrent flag missing");
   chk_ot_live: assert property (ot_rise |-> ot_seen)
      else $error("thermal flag or pass off missing");
   chk_undervoltage_lockout_clear: assert property (undervoltage_lockout [*5]
      |-> regulator_output == 6'h00 && !boost_active)
      else $error("lockout did not clear code");
endmodule : smfdc_props

bind smfdc_top smfdc_props #(.BOOST_CYCLES(BOOST_CYCLES)) u_props (
   .sys_clk(sys_clk), .rst(rst), .scl_clk(scl_clk), .sda_level(sda_level),
   .sda_drive(sda_drive), .sda_drive_en(sda_drive_en), .current_limit(current_limit),
   .thermal_shutdown(thermal_shutdown), .undervoltage_lockout(undervoltage_lockout),
   .regulator_output(regulator_output), .boost_active(boost_active),
   .pass_enable(pass_enable), .overcurrent_flag(overcurrent_flag),
   .overtemp_flag(overtemp_flag), .link_busy(link_busy));

// ===== smfdc_sync.sv
// Purpose: Two flip-flop synchroniser for a group of levels
// Assumes: Each lane is an independent level
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module smfdc_sync #(
   parameter int unsigned W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] async_level,
   output logic      [W-1:0] sync_level
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } smfdc_sync_st_t;

   smfdc_sync_st_t q;
   smfdc_sync_st_t d;

   if (W < 1) begin : g_chk
      $error("smfdc_sync width must be at least one");
   end

   always_comb begin
      d.meta   = async_level;
      d.stable = q.meta;
      if (rst) begin
         d.meta   = RST_VAL;
         d.stable = RST_VAL;
      end
   end

   always_ff @(posedge sys_clk) begin
      q <= d;
   end

   assign sync_level = q.stable;

endmodule : smfdc_sync

// ===== smfdc_top.sv
// Purpose: Two-wire slave that sets a fan supply DAC code and reports faults
// Assumes: Raw bus pins and fault levels arrive unsynchronised
// Notes:   Data bits are sampled on the bus clock; decoding runs on sys_clk
`timescale 1ns/1ps
// How it works
// - Frame opens with start, 7-bit address, direction; matching address acked low.
// - Direction low means send byte, high means receive byte.
// - Write carries an 8-bit command after the address; it is acked.
// - Command moves into the DAC latch at the ack clock falling edge.
// - Read acks address, sends a fresh status byte after each host ack; host ends with nack, stop.
// - Status goes MSB first: overcurrent, over-temperature, six zeros.
// - Thermal shutdown turns off the pass element and sets status bit six.
// - Current limiting sets status bit seven.
// - Boost start drives full scale for 250 ms, then the programmed code.
// - After power-up the output code stays zero until programmed.
// - Six-bit code; 63 is full scale, zero is minimum.
// - Serial data is sampled on the rising bus clock edge.
// - Data line is only pulled low or released, never driven high.
// - A fault flag of one means that fault is active.
// - Only the fixed address 1110100 is answered.
// - Stop before the command ack discards the byte, latch unchanged.
// - Reset and undervoltage lockout clear all command and status bits.
module smfdc_top #(
   parameter int unsigned BOOST_CYCLES = smfdc_pkg::BOOST_CYCLES
) (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       scl_clk,
   input  wire logic       sda_level,
   output logic            sda_drive,
   output logic            sda_drive_en,
   input  wire logic       current_limit,
   input  wire logic       thermal_shutdown,
   input  wire logic       undervoltage_lockout,
   output logic [5:0]      regulator_output,
   output logic            boost_active,
   output logic            pass_enable,
   output logic            overcurrent_flag,
   output logic            overtemp_flag,
   output logic            link_busy
);

   localparam int unsigned CNT_W = $clog2(BOOST_CYCLES + 1);
   localparam logic [CNT_W-1:0] BOOST_LOAD = CNT_W'(BOOST_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO   = '0;

   if (BOOST_CYCLES < 1) begin : g_chk
      $error("smfdc_top boost count must be at least one cycle");
   end

   if (smfdc_pkg::CODE_W != 6) begin : g_chk_code
      $error("smfdc_top code width must match the output code port");
   end

   typedef struct packed {
      smfdc_pkg::smfdc_state_t state;
      logic [2:0]              bit_cnt;
      logic [7:0]              shift;
      logic                    read_dir;
      logic                    ack_phase;
      logic                    tgl_seen;
      logic                    scl_prev;
      logic                    sda_prev;
      logic                    sda_drive;
      logic                    sda_drive_en;
      logic [5:0]              code;
      logic                    boost_req;
      logic                    boost_run;
      logic [CNT_W-1:0]        boost_cnt;
      logic [5:0]              dac_code;
      logic                    pass_enable;
      logic                    oc_flag;
      logic                    ot_flag;
      logic                    busy;
   } smfdc_top_st_t;

   localparam smfdc_top_st_t ST_RESET = '0;

   // Status byte as it leaves the shifter
   function automatic logic [7:0] status_byte(
      input logic oc,
      input logic ot
   );
      logic [7:0] s;
      s = smfdc_pkg::STAT_ZERO;
      s[smfdc_pkg::STAT_OC_BIT] = oc;
      s[smfdc_pkg::STAT_OT_BIT] = ot;
      return s;
   endfunction : status_byte

   // Open-drain enable for a data bit: pull low only for a zero
   function automatic logic pull_for(
      input logic b
   );
      return ~b;
   endfunction : pull_for

   // Bit counter step, wraps to zero after the eighth bit
   function automatic logic [2:0] next_cnt(
      input logic [2:0] c
   );
      return c + 3'h1;
   endfunction : next_cnt

   // High on the eighth bit of a byte
   function automatic logic is_last(
      input logic [2:0] c
   );
      return c == smfdc_pkg::BIT_LAST;
   endfunction : is_last

   smfdc_top_st_t q;
   smfdc_top_st_t d;

   logic [smfdc_pkg::SYNC_W-1:0] sy;
   logic                         link_bit;
   logic                         link_tgl;

   logic                         scl_s;
   logic                         sda_s;
   logic                         oc_s;
   logic                         ot_s;
   logic                         undervoltage_lockout_s;
   logic                         tgl_s;

   logic                         ev_fall;
   logic                         ev_start;
   logic                         ev_stop;
   logic                         ev_bit;
   logic [7:0]                   next_byte;
   logic                         ack_end;
   logic                         clear_all;

   smfdc_link_capture u_link (
      .scl_clk    (scl_clk),
      .rst        (rst),
      .sda_level  (sda_level),
      .bit_value  (link_bit),
      .bit_toggle (link_tgl)
   );

   smfdc_sync #(
      .W       (smfdc_pkg::SYNC_W),
      .RST_VAL (smfdc_pkg::SYNC_RST)
   ) u_sync (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .async_level ({link_tgl, undervoltage_lockout, thermal_shutdown,
                     current_limit, sda_level, scl_clk}),
      .sync_level  (sy)
   );

   assign scl_s  = sy[smfdc_pkg::SY_SCL];
   assign sda_s  = sy[smfdc_pkg::SY_SDA];
   assign oc_s   = sy[smfdc_pkg::SY_OC];
   assign ot_s   = sy[smfdc_pkg::SY_OT];
   assign undervoltage_lockout_s = sy[smfdc_pkg::SY_UNDERVOLTAGE_LOCKOUT];
   assign tgl_s  = sy[smfdc_pkg::SY_TGL];

   // Bus conditions seen on the synchronised lines
   assign ev_fall  = q.scl_prev & ~scl_s;
   assign ev_start = scl_s & q.scl_prev & q.sda_prev & ~sda_s;
   assign ev_stop  = scl_s & q.scl_prev & ~q.sda_prev & sda_s;

   // New bit: link_bit is stable for a whole clock phase once seen
   assign ev_bit    = tgl_s ^ q.tgl_seen;
   assign next_byte = {q.shift[6:0], link_bit};

   // Falling edge that closes the command ack clock
   assign ack_end   = ev_fall & (q.state == smfdc_pkg::ST_CMD_ACK) & q.ack_phase;
   // Lockout clears the same state as reset
   assign clear_all = rst | undervoltage_lockout_s;

   always_comb begin
      d = q;
      d.scl_prev  = scl_s;
      d.sda_prev  = sda_s;
      d.tgl_seen  = tgl_s;
      d.sda_drive = 1'b0;

      // Frame decoding
      if (ev_stop) begin
         // Unacked command byte is simply dropped
         d.state        = smfdc_pkg::ST_IDLE;
         d.sda_drive_en = 1'b0;
         d.ack_phase    = 1'b0;
      end else if (ev_start) begin
         d.state        = smfdc_pkg::ST_ADDR;
         d.bit_cnt      = 3'h0;
         d.sda_drive_en = 1'b0;
         d.ack_phase    = 1'b0;
      end else begin
         case (q.state)
            smfdc_pkg::ST_IDLE: begin
               d.sda_drive_en = 1'b0;
            end

            smfdc_pkg::ST_ADDR: begin
               if (ev_bit) begin
                  d.shift   = next_byte;
                  d.bit_cnt = next_cnt(q.bit_cnt);
                  if (is_last(q.bit_cnt)) begin
                     if (next_byte[7:1] == smfdc_pkg::SLAVE_ADDR) begin
                        d.state    = smfdc_pkg::ST_ADDR_ACK;
                        d.read_dir = next_byte[0];
                     end else begin
                        d.state = smfdc_pkg::ST_IDLE;
                     end
                  end
               end
            end

            smfdc_pkg::ST_ADDR_ACK: begin
               if (ev_fall) begin
                  if (!q.ack_phase) begin
                     d.sda_drive_en = 1'b1;
                     d.ack_phase    = 1'b1;
                  end else begin
                     d.ack_phase = 1'b0;
                     d.bit_cnt   = 3'h0;
                     if (q.read_dir == smfdc_pkg::DIR_READ) begin
                        d.shift        = status_byte(oc_s, ot_s);
                        d.sda_drive_en = pull_for(d.shift[7]);
                        d.state        = smfdc_pkg::ST_TX;
                     end else begin
                        d.sda_drive_en = 1'b0;
                        d.state        = smfdc_pkg::ST_CMD;
                     end
                  end
               end
            end

            smfdc_pkg::ST_CMD: begin
               if (ev_bit) begin
                  d.shift   = next_byte;
                  d.bit_cnt = next_cnt(q.bit_cnt);
                  if (is_last(q.bit_cnt)) begin
                     d.state = smfdc_pkg::ST_CMD_ACK;
                  end
               end
            end

            smfdc_pkg::ST_CMD_ACK: begin
               if (ev_fall) begin
                  if (!q.ack_phase) begin
                     d.sda_drive_en = 1'b1;
                     d.ack_phase    = 1'b1;
                  end else begin
                     // Falling edge that ends the ack clock
                     d.ack_phase    = 1'b0;
                     d.sda_drive_en = 1'b0;
                     d.code = q.shift[smfdc_pkg::CMD_CODE_LSB +: smfdc_pkg::CODE_W];
                     d.boost_req = q.shift[smfdc_pkg::CMD_BOOST_BIT];
                     d.boost_run = q.shift[smfdc_pkg::CMD_BOOST_BIT];
                     d.boost_cnt = BOOST_LOAD;
                     d.state     = smfdc_pkg::ST_IDLE;
                  end
               end
            end

            smfdc_pkg::ST_TX: begin
               if (ev_fall) begin
                  d.shift   = {q.shift[6:0], 1'b0};
                  d.bit_cnt = next_cnt(q.bit_cnt);
                  if (is_last(q.bit_cnt)) begin
                     d.sda_drive_en = 1'b0;
                     d.state        = smfdc_pkg::ST_TX_ACK;
                  end else begin
                     d.sda_drive_en = pull_for(q.shift[6]);
                  end
               end
            end

            smfdc_pkg::ST_TX_ACK: begin
               if (ev_bit) begin
                  if (link_bit) begin
                     // Host nack: wait for its stop
                     d.state = smfdc_pkg::ST_IDLE;
                  end else begin
                     d.state = smfdc_pkg::ST_RELOAD;
                  end
               end
            end

            smfdc_pkg::ST_RELOAD: begin
               // Host acked anyway: send a fresh status byte
               if (ev_fall) begin
                  d.shift        = status_byte(oc_s, ot_s);
                  d.sda_drive_en = pull_for(d.shift[7]);
                  d.bit_cnt      = 3'h0;
                  d.state        = smfdc_pkg::ST_TX;
               end
            end

            default: begin
               d.state        = smfdc_pkg::ST_IDLE;
               d.sda_drive_en = 1'b0;
            end
         endcase
      end

      // Boost start timer
      if (q.boost_run && !ack_end) begin
         if (q.boost_cnt == CNT_ZERO) begin
            d.boost_run = 1'b0;
         end else begin
            d.boost_cnt = q.boost_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end

      // Output code: full scale while boosting, else programmed
      d.dac_code = d.boost_run ? smfdc_pkg::CODE_FULL : d.code;

      // Live fault levels, one means active
      d.oc_flag     = oc_s;
      d.ot_flag     = ot_s;
      d.pass_enable = ~ot_s;
      d.busy        = (d.state != smfdc_pkg::ST_IDLE);

      // Power-on and undervoltage clear everything
      if (clear_all) begin
         d = ST_RESET;
         d.code     = smfdc_pkg::CODE_RST;
         d.dac_code = smfdc_pkg::CODE_RST;
         d.scl_prev = 1'b1;
         d.sda_prev = 1'b1;
         d.tgl_seen = tgl_s;
      end
   end

   always_ff @(posedge sys_clk) begin
      q <= d;
   end

   assign sda_drive        = q.sda_drive;
   assign sda_drive_en     = q.sda_drive_en;
   assign regulator_output = q.dac_code;
   assign boost_active     = q.boost_run;
   assign pass_enable      = q.pass_enable;
   assign overcurrent_flag = q.oc_flag;
   assign overtemp_flag    = q.ot_flag;
   assign link_busy        = q.busy;

endmodule : smfdc_top

// ===== tb_smbus_fan_dac_control.sv
// Purpose: Self-checking bench for the fan supply DAC control slave
// Assumes: Host model owns the bus pins; bench owns fault levels
// Notes:   Boost time shortened to 400 cycles
`timescale 1ns/1ps
module tb_smbus_fan_dac_control;
   localparam int unsigned BOOST = 400;
   logic       sys_clk;
   logic       rst;
   logic       current_limit;
   logic       thermal_shutdown;
   logic       undervoltage_lockout;
   wire        scl_clk;
   wire        sda_low;
   wire        sda_level;
   logic       sda_drive;
   logic       sda_drive_en;
   logic [5:0] regulator_output;
   logic       boost_active;
   logic       pass_enable;
   logic       overcurrent_flag;
   logic       overtemp_flag;
   logic       link_busy;
   logic [1:0] acks;
   logic [7:0] stat;
   logic       ack;
   logic [5:0] codes [4] = '{6'h2a, 6'h3f, 6'h00, 6'h15};
   int         err_count = 0;
   int         tests_run = 0;

   assign sda_level = ~(sda_low | (sda_drive_en & ~sda_drive));

   smfdc_top #(.BOOST_CYCLES(BOOST)) u_dut (
      .sys_clk(sys_clk), .rst(rst), .scl_clk(scl_clk), .sda_level(sda_level),
      .sda_drive(sda_drive), .sda_drive_en(sda_drive_en), .current_limit(current_limit),
      .thermal_shutdown(thermal_shutdown), .undervoltage_lockout(undervoltage_lockout),
      .regulator_output(regulator_output), .boost_active(boost_active),
      .pass_enable(pass_enable), .overcurrent_flag(overcurrent_flag),
      .overtemp_flag(overtemp_flag), .link_busy(link_busy));

   smfdc_host u_host (.scl_clk(scl_clk), .sda_low(sda_low), .sda_level(sda_level));

   always #4 sys_clk = ~sys_clk;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out

   task automatic wr(input logic [7:0] cmd, input int n, input logic [1:0] exp_ack);
      u_host.write_cmd(7'h74, cmd, n, acks);
      repeat (4) @(posedge sys_clk);
      check({6'h00, acks}, {6'h00, exp_ack});
      check({7'h00, link_busy}, 8'h00);
   endtask : wr

   initial begin
      #600_000;
      err_count++;
      close_out();
   end

   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      current_limit = 1'b0;
      thermal_shutdown = 1'b0;
      undervoltage_lockout = 1'b0;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check({2'b00, regulator_output}, 8'h00);
      check({7'h00, boost_active}, 8'h00);
      check({7'h00, sda_drive}, 8'h00);
      check({7'h00, link_busy}, 8'h00);
      $display("test reset done");
      foreach (codes[i]) begin
         wr({2'b00, codes[i]}, 8, 2'b11);
         check({2'b00, regulator_output}, {2'b00, codes[i]});
      end
      $display("test codes done");
      u_host.write_cmd(7'h75, 8'h3f, 8, acks);
      check({6'h00, acks}, 8'h00);
      wr(8'h07, 4, 2'b10);
      check({2'b00, regulator_output}, 8'h15);
      wr(8'h8c, 8, 2'b11);
      check({2'b00, regulator_output}, 8'h0c);
      $display("test refuse done");
      wr(8'h45, 8, 2'b11);
      check({1'b0, boost_active, regulator_output}, 8'h7f);
      repeat (BOOST) @(posedge sys_clk);
      check({1'b0, boost_active, regulator_output}, 8'h05);
      $display("test boost done");
      for (int k = 0; k < 4; k++) begin
         current_limit <= k[1];
         thermal_shutdown <= k[0];
         repeat (8) @(posedge sys_clk);
         u_host.read_stat(7'h74, k % 2, stat, ack);
         check({7'h00, ack}, 8'h01);
         check(stat, {k[1], k[0], 6'h00});
         check({6'h00, overcurrent_flag, overtemp_flag}, {6'h00, k[1], k[0]});
         check({7'h00, pass_enable}, {7'h00, ~k[0]});
      end
      current_limit <= 1'b0;
      thermal_shutdown <= 1'b0;
      $display("test status done");
      wr(8'h45, 8, 2'b11);
      undervoltage_lockout <= 1'b1;
      repeat (8) @(posedge sys_clk);
      check({1'b0, boost_active, regulator_output}, 8'h00);
      undervoltage_lockout <= 1'b0;
      repeat (8) @(posedge sys_clk);
      wr(8'h21, 8, 2'b11);
      check({2'b00, regulator_output}, 8'h21);
      $display("test lockout done");
      close_out();
   end
endmodule : tb_smbus_fan_dac_control
